/* verilog/sac_top.sv */
// control logic of the 8-bit successive-approximation converter with apb registers
// Function
// - four inputs muxed into sample-and-hold
// - 8-bit result by successive approximation
// - reference is supply or channel-3 pin
// - convert in sleep only on rc clock
// - result, control, pin config registers
// - pin config sets analog, digital, reference
// - channel select bits 4:3 pick input
// - done flag set by hardware, software clears
// - flag sets regardless of interrupt enables
// - start delayed one instruction cycle
// - completion clears go, sets done flag
// - rc conversion finishes during sleep
// - sleep aborts non-rc conversion, done flag not set, abort status set
// - power on acquires; off does nothing
// - first code step at vref over 256
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sac_top
    import sac_pkg::*;
#(
    parameter int RES_W = SAC_RESULT_BITS
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic cmp_high,
    output logic [1:0] mux_channel,
    output logic ref_is_pin,
    output logic [3:0] pin_analog,
    output logic sample_hold,
    output logic [7:0] dac_code,
    output logic analog_power,
    output logic irq
);
    // ****************************************
    // registers and state
    // ****************************************
    logic [7:0] control_r;      // converter_control
    logic [7:0] result_r;       // conversion_result
    logic [7:0] pincfg_r;       // analog_pin_config
    logic [SAC_IRQ_W-1:0] ist_r; // sticky event status
    logic [SAC_IRQ_W-1:0] imask_r; // interrupt mask
    logic sleep_r;              // registered sleep state
    sac_state_t state_r;        // conversion sequencer
    sac_sar_t sar_r;            // trial code and current bit
    logic [1:0] dly_r;          // instruction-cycle delay count
    logic [1:0] fin_r;          // finish period count
    logic tick;                 // one bit period elapsed
    logic done_ev;              // conversion completes this cycle
    logic abort_ev;             // conversion aborted this cycle

    // ****************************************
    // bus decode
    // ****************************************
    logic wr_acc;
    logic rd_sel;
    logic known;
    assign wr_acc = psel && penable && pwrite;
    assign rd_sel = psel && !penable;

    // address is one of the implemented words
    function automatic logic addr_known(input logic [11:0] a);
        return (a == SAC_OFF_CONTROL) || (a == SAC_OFF_RESULT) || (a == SAC_OFF_PINCFG) ||
               (a == SAC_OFF_IRQ_STATUS) || (a == SAC_OFF_IRQ_MASK) ||
               (a == SAC_OFF_SYS);
    endfunction
    assign known = addr_known(paddr);

    // write strobe for one address
    function automatic logic wr_hit(input logic acc, input logic [11:0] a,
                                    input logic [11:0] off);
        return acc && (a == off);
    endfunction

    logic go_bit;
    logic power_bit;
    logic rc_clk;
    assign go_bit = control_r[SAC_BIT_GO];
    assign power_bit = control_r[SAC_BIT_POWER];
    assign rc_clk = control_r[SAC_CLK_LO+1 -: 2] == SAC_CLK_RC;

    // ****************************************
    // bit period generator
    // ****************************************
    sac_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(state_r == SAC_CONVERT || state_r == SAC_FINISH),
        .clk_sel(control_r[SAC_CLK_LO+1 -: 2]),
        .tick(tick)
    );

    // ****************************************
    // sleep tracking
    // ****************************************
    // sleep is a level from the core, taken as synchronous
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_r <= 1'b0;
        else
            sleep_r <= sleep_req;
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    // abort only when asleep with a non-rc clock while busy
    assign abort_ev = sleep_r && !rc_clk && (state_r != SAC_IDLE);
    assign done_ev = (state_r == SAC_FINISH) && tick && (fin_r == 2'(SAC_FINISH_PERIODS - 1))
                     && !abort_ev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= SAC_IDLE;
            sar_r <= '0;
            dly_r <= 2'h0;
            fin_r <= 2'h0;
        end
        else if (!power_bit || abort_ev)
        begin
            state_r <= SAC_IDLE;
            sar_r <= '0;
        end
        else
        begin
            case (state_r)
                SAC_IDLE:
                begin
                    // go seen: wait one instruction cycle before sampling stops
                    if (go_bit)
                    begin
                        state_r <= SAC_DELAY;
                        dly_r <= 2'h0;
                    end
                end
                SAC_DELAY:
                begin
                    dly_r <= dly_r + 2'h1;
                    if (dly_r == 2'(SAC_INSTR_CLKS - 1))
                    begin
                        state_r <= SAC_CONVERT;
                        sar_r.trial <= 8'h80;
                        sar_r.bitsel <= 8'h80;
                    end
                end
                SAC_CONVERT:
                begin
                    // one bit decided per bit period, msb first
                    if (tick)
                    begin
                        if (!cmp_high)
                            sar_r.trial <= sar_r.trial & ~sar_r.bitsel;
                        if (sar_r.bitsel == 8'h01)
                        begin
                            state_r <= SAC_FINISH;
                            fin_r <= 2'h0;
                        end
                        else
                        begin
                            sar_r.bitsel <= sar_r.bitsel >> 1;
                            sar_r.trial <= (sar_r.trial & ~(cmp_high ? 8'h00 : sar_r.bitsel))
                                           | (sar_r.bitsel >> 1);
                        end
                    end
                end
                SAC_FINISH:
                begin
                    if (tick)
                    begin
                        fin_r <= fin_r + 2'h1;
                        if (done_ev)
                            state_r <= SAC_IDLE;
                    end
                end
                default: state_r <= SAC_IDLE;
            endcase
        end
    end

    // ****************************************
    // control register
    // ****************************************
    // done flag: set wins over a software clear; go cleared by completion or abort
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_r <= SAC_CONTROL_RESET;
        else
        begin
            if (wr_hit(wr_acc, paddr, SAC_OFF_CONTROL))
            begin
                control_r <= pwdata[7:0] & SAC_CONTROL_WMASK;
                control_r[SAC_BIT_DONE_FLAG] <= pwdata[SAC_BIT_DONE_FLAG];
            end
            if (done_ev)
            begin
                control_r[SAC_BIT_GO] <= 1'b0;
                control_r[SAC_BIT_DONE_FLAG] <= 1'b1;
            end
            else if (abort_ev)
                control_r[SAC_BIT_GO] <= 1'b0;
        end
    end

    // ****************************************
    // result and pin config
    // ****************************************
    // result captured on the completion edge, same edge as the flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            result_r <= SAC_RESULT_RESET;
        else if (done_ev)
            result_r <= sar_r.trial;
        else if (wr_hit(wr_acc, paddr, SAC_OFF_RESULT))
            result_r <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pincfg_r <= SAC_PINCFG_RESET;
        else if (wr_hit(wr_acc, paddr, SAC_OFF_PINCFG))
            pincfg_r <= pwdata[7:0];
    end

    // ****************************************
    // interrupts
    // ****************************************
    // events set sticky bits; write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ist_r <= '0;
        else
        begin
            for (int i = 0; i < SAC_IRQ_W; i++)
            begin
                if ((i == SAC_IRQ_DONE && done_ev) || (i == SAC_IRQ_ABORT && abort_ev))
                    ist_r[i] <= 1'b1;
                else if (wr_hit(wr_acc, paddr, SAC_OFF_IRQ_STATUS) && pwdata[i])
                    ist_r[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            imask_r <= '0;
        else if (wr_hit(wr_acc, paddr, SAC_OFF_IRQ_MASK))
            imask_r <= pwdata[SAC_IRQ_W-1:0];
    end

    // ****************************************
    // outputs
    // ****************************************
    // analog side driven from flops so glitches never reach the comparator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
            mux_channel <= 2'h0;
            ref_is_pin <= 1'b0;
            pin_analog <= 4'h0;
            sample_hold <= 1'b0;
            dac_code <= 8'h00;
            analog_power <= 1'b0;
        end
        else
        begin
            irq <= |(ist_r & imask_r);
            mux_channel <= control_r[SAC_CHAN_LO+1 -: 2];
            ref_is_pin <= pincfg_r[SAC_BIT_POWER];
            pin_analog <= pincfg_r[7:4];
            // acquire while powered and not converting
            sample_hold <= power_bit && (state_r == SAC_IDLE || state_r == SAC_DELAY);
            // dac trial relative to vref/256 steps
            dac_code <= sar_r.trial;
            analog_power <= power_bit;
        end
    end

    // ****************************************
    // apb read and answer
    // ****************************************
    // zero-wait slave: answer in the access phase, error on unmapped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= rd_sel;
            pslverr <= rd_sel && !known;
            prdata <= 32'h00000000;
            if (rd_sel)
            begin
                case (paddr)
                    SAC_OFF_CONTROL: prdata <= {24'h000000, control_r};
                    SAC_OFF_RESULT: prdata <= {24'h000000, result_r};
                    SAC_OFF_PINCFG: prdata <= {24'h000000, pincfg_r};
                    SAC_OFF_IRQ_STATUS: prdata <= {30'h0, ist_r};
                    SAC_OFF_IRQ_MASK: prdata <= {30'h0, imask_r};
                    SAC_OFF_SYS: prdata <= {30'h0, state_r};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    done_go_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_ev |=> !control_r[SAC_BIT_GO] && control_r[SAC_BIT_DONE_FLAG])
        else $error("completion did not clear go or set flag");
    result_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_ev |=> result_r == $past(sar_r.trial))
        else $error("result not captured at completion");
    abort_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
        abort_ev && !done_ev |=> !control_r[SAC_BIT_GO] && state_r == SAC_IDLE)
        else $error("abort left converter busy");
    start_dly_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == SAC_IDLE && go_bit && power_bit && !abort_ev |=> state_r == SAC_DELAY
        ##0 (state_r == SAC_DELAY)[*4])
        else $error("start not delayed one instruction cycle");
    power_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !power_bit |=> state_r == SAC_IDLE && !sample_hold)
        else $error("converter active while powered off");
    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        control_r[SAC_BIT_DONE_FLAG] && !wr_hit(wr_acc, paddr, SAC_OFF_CONTROL)
        |=> control_r[SAC_BIT_DONE_FLAG])
        else $error("done flag cleared by hardware");
    bit5_zero_a: assert property (@(posedge pclk) disable iff (!presetn) !control_r[5])
        else $error("unused control bit set");
    chan_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> mux_channel == $past(control_r[4:3]))
        else $error("channel output mismatch");
    rc_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_r && rc_clk && state_r == SAC_CONVERT && power_bit |=> state_r != SAC_IDLE)
        else $error("rc conversion stopped in sleep");
    done_c: cover property (@(posedge pclk) disable iff (!presetn) done_ev);
    abort_c: cover property (@(posedge pclk) disable iff (!presetn) abort_ev);
    irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule
`default_nettype wire

/* verilog/sac_pkg.sv */
// package with register map, field layout and timing counts of the converter control
package sac_pkg;
    // ****************************************
    // register indices and byte addresses
    // ****************************************
    // one 32-bit word per register: the byte address is four times the index
    localparam logic [11:0] SAC_IDX_CONTROL = 12'h008;
    localparam logic [11:0] SAC_IDX_RESULT = 12'h009;
    localparam logic [11:0] SAC_IDX_PINCFG = 12'h088;
    localparam logic [11:0] SAC_OFF_CONTROL = SAC_IDX_CONTROL << 2;
    localparam logic [11:0] SAC_OFF_RESULT = SAC_IDX_RESULT << 2;
    localparam logic [11:0] SAC_OFF_PINCFG = SAC_IDX_PINCFG << 2;
    // own words, already word aligned
    localparam logic [11:0] SAC_OFF_IRQ_STATUS = 12'h100;
    localparam logic [11:0] SAC_OFF_IRQ_MASK = 12'h104;
    localparam logic [11:0] SAC_OFF_SYS = 12'h108;
    // ****************************************
    // control register fields
    // ****************************************
    localparam int SAC_BIT_POWER = 0;
    localparam int SAC_BIT_DONE_FLAG = 1;
    localparam int SAC_BIT_GO = 2;
    localparam int SAC_CHAN_LO = 3;
    localparam int SAC_CLK_LO = 6;
    localparam logic [7:0] SAC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SAC_RESULT_RESET = 8'h00;
    localparam logic [7:0] SAC_PINCFG_RESET = 8'h00;
    // control bits that software may write; bit 5 and the done flag handled apart
    localparam logic [7:0] SAC_CONTROL_WMASK = 8'hdd;
    // ****************************************
    // clock select codes
    // ****************************************
    localparam logic [1:0] SAC_CLK_DIV2 = 2'h0;
    localparam logic [1:0] SAC_CLK_DIV8 = 2'h1;
    localparam logic [1:0] SAC_CLK_DIV32 = 2'h2;
    localparam logic [1:0] SAC_CLK_RC = 2'h3;
    // ****************************************
    // timing
    // ****************************************
    localparam int SAC_RESULT_BITS = 8;
    localparam int SAC_CHANNELS = 4;
    localparam int SAC_INSTR_CLKS = 4;     // one instruction cycle in clocks
    localparam int SAC_RC_DIV = 16;        // rc oscillator period in clocks
    localparam int SAC_FINISH_PERIODS = 2; // extra bit periods after last bit
    // ****************************************
    // interrupt bits
    // ****************************************
    localparam int SAC_IRQ_DONE = 0;
    localparam int SAC_IRQ_ABORT = 1;
    localparam int SAC_IRQ_W = 2;
    // ****************************************
    // carrier for the sar step
    // ****************************************
    typedef struct packed {
        logic [7:0] trial;
        logic [7:0] bitsel;
    } sac_sar_t;
    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_DELAY,
        SAC_CONVERT,
        SAC_FINISH
    } sac_state_t;
endpackage

/* verilog/sac_tick.sv */
// bit period tick generator for the converter clock selection
`timescale 1ns/10ps
`default_nettype none
module sac_tick
    import sac_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [1:0] clk_sel,
    output logic tick
);
    // divider counter
    logic [5:0] cnt_r;
    logic [5:0] lim;

    // limit per clock select code
    always_comb
    begin
        case (clk_sel)
            SAC_CLK_DIV2: lim = 6'd1;
            SAC_CLK_DIV8: lim = 6'd7;
            SAC_CLK_DIV32: lim = 6'd31;
            default: lim = 6'(SAC_RC_DIV - 1);
        endcase
    end

    // count while running, restart when idle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= 6'h00;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            cnt_r <= 6'h00;
            tick <= 1'b0;
        end
        else if (cnt_r >= lim)
        begin
            cnt_r <= 6'h00;
            tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 6'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* testbench/sac_ain_model.sv */
// analog side model: four input levels and the comparator behind the trial dac
`timescale 1ns/10ps
`default_nettype none
module sac_ain_model
    import sac_pkg::*;
(
    input wire logic pclk,
    input wire logic [31:0] levels,
    input wire logic [1:0] mux_channel,
    input wire logic [7:0] dac_code,
    input wire logic analog_power,
    output logic cmp_high
);
    logic junk_r; // flips every cycle so an unpowered comparator never looks settled
    logic [7:0] vin; // level of the routed input
    // free running junk, starts unknown and is forced to a known value on the first edge
    always @(posedge pclk)
    begin
        junk_r <= (junk_r === 1'b1) ? 1'b0 : 1'b1;
    end
    // four-way input mux
    assign vin = levels[{mux_channel, 3'h0} +: 8];
    // first code step at one lsb: input at or above the trial code reads high
    assign cmp_high = analog_power ? (vin >= dac_code) : junk_r;
endmodule
`default_nettype wire

/* testbench/tb_sar_adc_control.sv */
// self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_sar_adc_control
    import sac_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    logic pclk, presetn, psel, penable, pwrite, sleep_req, cmp_high;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, ref_is_pin, sample_hold, analog_power, irq;
    logic [1:0] mux_channel;
    logic [3:0] pin_analog;
    logic [7:0] dac_code;
    logic [31:0] levels = 32'ha501ff00; // inputs 3..0, both extremes and one lsb
    logic [31:0] rd; // last read data
    logic err; // last slave error
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    sac_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .cmp_high(cmp_high),
        .mux_channel(mux_channel), .ref_is_pin(ref_is_pin), .pin_analog(pin_analog),
        .sample_hold(sample_hold), .dac_code(dac_code), .analog_power(analog_power),
        .irq(irq));
    sac_ain_model ain_u (.pclk(pclk), .levels(levels), .mux_channel(mux_channel),
        .dac_code(dac_code), .analog_power(analog_power), .cmp_high(cmp_high));
    // 100 mhz clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // hang guard, well above the slowest run
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    // ****************************************
    // bus and helper tasks
    // ****************************************
    // one apb transfer; the request stands until pready is seen high
    // no wait limit here: only the hang guard ends a stuck transfer
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll the control register until go drops, bounded
    task automatic wait_idle();
        int i;
        i = 0;
        do
        begin
            apb(1'b0, SAC_OFF_CONTROL, 32'h0);
            i++;
        end
        while (rd[SAC_BIT_GO] !== 1'b0 && i < 400);
        if (i == 400) n_fail++;
    endtask
    // powered start with the flag written back to zero
    task automatic start(input logic [1:0] cs, input logic [1:0] ch);
        apb(1'b1, SAC_OFF_CONTROL, {24'h0, cs, 1'b0, ch, 3'b101});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // reset values, the dead bit 5 and an unmapped address
    task automatic t_reset();
        apb(1'b1, SAC_OFF_CONTROL, 32'h20);
        apb(1'b0, SAC_OFF_CONTROL, 32'h0);
        `CHK(rd, 32'h0)
        `CHK({analog_power, sample_hold}, 2'b00)
        apb(1'b0, SAC_OFF_RESULT, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b0, SAC_OFF_SYS, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, SAC_OFF_PINCFG, 32'ha1);
        apb(1'b0, SAC_OFF_PINCFG, 32'h0);
        `CHK({rd, pin_analog, ref_is_pin}, {32'ha1, 4'ha, 1'b1})
        apb(1'b1, SAC_OFF_PINCFG, 32'h50);
        repeat (2) @(negedge pclk);
        `CHK({pin_analog, ref_is_pin}, 5'h0a)
        $display("test reset and pins finished");
    endtask
    // every clock code on every channel: result, timing, flags
    task automatic t_conv();
        int per, el, t0;
        for (int c = 0; c < 4; c++)
            for (int h = 0; h < 4; h++)
            begin
                per = (c == 0) ? 2 : (c == 1) ? 8 : (c == 2) ? 32 : 16;
                start(c[1:0], h[1:0]);
                t0 = cycles;
                apb(1'b0, SAC_OFF_CONTROL, 32'h0);
                `CHK({rd[SAC_BIT_GO], mux_channel}, {1'b1, h[1:0]})
                wait_idle();
                el = cycles - t0;
                `CHK(el >= 10 * per && el <= 4 + 11 * per + 8, 1'b1)
                `CHK(rd, {24'h0, c[1:0], 1'b0, h[1:0], 3'b011})
                apb(1'b0, SAC_OFF_RESULT, 32'h0);
                `CHK(rd, {24'h0, levels[h * 8 +: 8]})
            end
        `CHK(sample_hold, 1'b1)
        $display("test conversions finished");
    endtask
    // flag rises with the interrupt masked; irq follows the mask and status
    task automatic t_irq();
        apb(1'b1, SAC_OFF_IRQ_MASK, 32'h0);
        apb(1'b1, SAC_OFF_IRQ_STATUS, 32'h3);
        start(SAC_CLK_DIV2, 2'h2);
        wait_idle();
        repeat (2) @(negedge pclk);
        `CHK({rd[SAC_BIT_DONE_FLAG], irq}, 2'b10)
        apb(1'b1, SAC_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(negedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, SAC_OFF_IRQ_STATUS, 32'h1);
        repeat (2) @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b0, SAC_OFF_CONTROL, 32'h0);
        `CHK(rd[SAC_BIT_DONE_FLAG], 1'b1)
        apb(1'b1, SAC_OFF_CONTROL, 32'h1);
        apb(1'b0, SAC_OFF_CONTROL, 32'h0);
        `CHK(rd, 32'h1)
        $display("test interrupt finished");
    endtask
    // core sleeps in mid conversion on channel 3
    task automatic t_sleep(input logic [1:0] cs, input logic [31:0] ec, input logic [31:0] es);
        apb(1'b1, SAC_OFF_IRQ_STATUS, 32'h3);
        start(cs, 2'h3);
        repeat (40) @(posedge pclk);
        sleep_req <= 1'b1;
        repeat (400) @(posedge pclk);
        sleep_req <= 1'b0;
        apb(1'b0, SAC_OFF_CONTROL, 32'h0);
        `CHK(rd, ec)
        apb(1'b0, SAC_OFF_IRQ_STATUS, 32'h0);
        `CHK(rd, es)
        $display("test sleep finished");
    endtask
    // go without power stays idle and dark
    task automatic t_power();
        apb(1'b1, SAC_OFF_CONTROL, 32'h4);
        repeat (40) @(posedge pclk);
        apb(1'b0, SAC_OFF_CONTROL, 32'h0);
        `CHK({rd[SAC_BIT_DONE_FLAG], analog_power, sample_hold}, 3'b000)
        apb(1'b1, SAC_OFF_CONTROL, 32'h0);
        $display("test power finished");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sleep_req = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_conv();
        t_irq();
        t_sleep(SAC_CLK_DIV8, 32'h59, 32'h2);
        t_sleep(SAC_CLK_RC, 32'hdb, 32'h1);
        apb(1'b0, SAC_OFF_RESULT, 32'h0);
        `CHK(rd, 32'ha5)
        t_power();
        conclude();
    end
endmodule
`default_nettype wire
